/* common/awpc_pkg.sv */
// Constants and types for the wake and power-loss control unit
package awpc_pkg;

	// ===========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
	localparam logic [7:0] IDX_IRQ_SEL   = 8'h70;
	localparam logic [7:0] IDX_WAKE_CTRL = 8'he0;
	localparam logic [7:0] IDX_KEY_INDEX = 8'he1;
	localparam logic [7:0] IDX_KEY_DATA  = 8'he2;
	localparam logic [7:0] IDX_STATUS    = 8'he3;
	localparam logic [7:0] IDX_LOSS_CTRL = 8'he4;
	localparam logic [7:0] IDX_AUX_CTRL  = 8'he6;

	// ===========================================================
	// Reset values and implemented-bit masks
	localparam logic [7:0] RST_ACTIVATE  = 8'h00;
	localparam logic [7:0] RST_IRQ_SEL   = 8'h00;
	localparam logic [7:0] RST_WAKE_CTRL = 8'h01;
	localparam logic [7:0] RST_KEY_INDEX = 8'h00;
	localparam logic [7:0] RST_STATUS    = 8'h08;
	localparam logic [7:0] RST_LOSS_CTRL = 8'h00;
	localparam logic [7:0] RST_AUX_CTRL  = 8'h10;
	localparam logic [7:0] MSK_ACTIVATE  = 8'h01;
	localparam logic [7:0] MSK_IRQ_SEL   = 8'h0f;
	localparam logic [7:0] MSK_WAKE_CTRL = 8'hf7;
	localparam logic [7:0] MSK_LOSS_CTRL = 8'he4;
	localparam logic [7:0] MSK_AUX_CTRL  = 8'h90;
	localparam logic [7:0] MSK_STATUS    = 8'h3f;

	// ===========================================================
	// Field positions
	localparam int WC_PANEL_BLOCK = 7;
	localparam int WC_KB_EN       = 6;
	localparam int WC_MS_EN       = 5;
	localparam int WC_MS_RIGHT    = 4;
	localparam int WC_SWAP        = 2;
	localparam int WC_MS_ANY      = 1;
	localparam int WC_KB_ANY      = 0;
	localparam int LC_SUPPLY_ON_N_MODE   = 7;
	localparam int LC_POLICY_HI   = 6;
	localparam int LC_POLICY_LO   = 5;
	localparam int LC_HUNT        = 2;
	localparam int AX_MS_EXT      = 7;
	localparam int AX_LAST_STATE  = 4;
	localparam int ST_STANDBY     = 5;
	localparam int ST_LOSS_OFF    = 4;
	localparam int ST_THERMAL     = 3;
	localparam int ST_PANEL       = 2;
	localparam int ST_MOUSE       = 1;
	localparam int ST_KEY         = 0;

	// ===========================================================
	// Key combination storage
	localparam int         KEY_SETS   = 3;
	localparam int         KEY_SLOTS  = 15;
	localparam logic [7:0] KEY_SET0   = 8'h00;
	localparam logic [7:0] KEY_SET1   = 8'h30;
	localparam logic [7:0] KEY_SET2   = 8'h40;
	localparam logic [7:0] KEY_RECENT = 8'h10;
	localparam logic [7:0] KEY_FILL   = 8'hff;
	localparam logic [7:0] KEY_END    = 8'h00;
	localparam logic [7:0] MS_SYNC    = 8'h08;

	// ===========================================================
	// Timing
	localparam int CLK_MHZ   = 250;
	localparam int PULSE_NS  = 1000;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;

	typedef enum logic [1:0] {
		POL_OFF  = 2'b00,
		POL_ON   = 2'b01,
		POL_PREV = 2'b10,
		POL_USER = 2'b11
	} awpc_policy_t;

	typedef enum logic [1:0] {
		MS_B0 = 2'b00,
		MS_B1 = 2'b01,
		MS_B2 = 2'b10
	} awpc_ms_state_t;

endpackage : awpc_pkg

/* rtl/awpc_wake_power.sv */
// Wake-up and power-loss control unit with AHB-Lite register access
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Operation
// R1 - Activation bit 0 enables the unit
// R2 - Low nibble selects the event interrupt line
// R3 - Panel switch wire-ANDed unless blocked
// R4 - Bit 6 enables keyboard wake pulse
// R5 - Bit 5 enables mouse wake pulse
// R6 - Mouse wake chosen by extended, right, any bits
// R7 - Swap bit exchanges keyboard and mouse ports
// R8 - Any-key bit: any byte or sequence
// R9 - Index reaches three stored key sets
// R10 - Index 0x10-0x1E reads recent keys
// R11 - Data register accesses indexed key; resets ones
// R12 - Status read-only, read clears, resets 0x08
// R13 - Bit 5 flags standby power cycle
// R14 - Bit 4 reports loss decision when enabled
// R15 - Bit 3 flags thermal shutdown
// R16 - Bit 2 flags panel switch event
// R17 - Bits 1,0 latch mouse, keyboard wake
// R18 - Supply-on mode: after pulse or resume
// R19 - Two-bit policy picks state after loss
// R20 - Last-state flag: 0 on, 1 off
// R21 - Hunting bit arms wake, self-clears on capture
// R22 - Enabled wake pulses power switch low
// R23 - Wake state kept in standby domain; the code resets it with hresetn like all else
module awpc_wake_power
	import awpc_pkg::*;
#(
	parameter int SLOTS        = KEY_SLOTS,
	parameter int PULSE_CYCLES = PULSE_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        port_a_valid,
	input  wire logic [7:0]  port_a_data,
	input  wire logic        port_b_valid,
	input  wire logic [7:0]  port_b_data,
	input  wire logic        panel_switch_in,
	input  wire logic        suspend_state_n,
	input  wire logic        thermal_event,
	input  wire logic        standby_return,
	input  wire logic        mains_return,
	output logic             power_switch_out_n,
	output logic             supply_on_n,
	output logic             power_event_n,
	output logic [3:0]       irq_line_select
);

	if (SLOTS < 2 || SLOTS > KEY_SLOTS)
		$error("SLOTS must lie in 2..15");
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535)
		$error("PULSE_CYCLES must lie in 1..65535");

	localparam logic [3:0]  SLOT_LAST = 4'(SLOTS - 1);
	localparam logic [15:0] PULSE_LEN = 16'(PULSE_CYCLES);

	// ===========================================================
	// Helpers
	function automatic logic decide_on(input logic [1:0] pol,
		input logic prev_on, input logic last_off);
		unique case (awpc_policy_t'(pol))
			POL_OFF:  decide_on = 1'b0;
			POL_ON:   decide_on = 1'b1;
			POL_PREV: decide_on = prev_on;
			POL_USER: decide_on = ~last_off; // R20
		endcase
	endfunction : decide_on

	// Returns hit, set number and slot for a key index
	function automatic logic [6:0] key_decode(input logic [7:0] idx);
		logic [7:0] base;
		logic [7:0] off;
		base = {idx[7:4], 4'h0};
		off  = idx - base;
		key_decode = 7'h00;
		if (off < 8'(SLOTS)) begin
			if (base == KEY_SET0)
				key_decode = {1'b1, 2'd0, off[3:0]};
			else if (base == KEY_SET1)
				key_decode = {1'b1, 2'd1, off[3:0]};
			else if (base == KEY_SET2)
				key_decode = {1'b1, 2'd2, off[3:0]};
		end
	endfunction : key_decode

	// ===========================================================
	// Register file state
	logic [7:0]  activate_r;
	logic [7:0]  irq_sel_r;
	logic [7:0]  wake_ctrl_r;
	logic [7:0]  key_index_r;
	logic [7:0]  loss_ctrl_r;
	logic [7:0]  aux_ctrl_r;
	logic [5:0]  status_r;
	logic [5:0]  status_set;
	logic [7:0]  key_mem_r [KEY_SETS][KEY_SLOTS];
	logic [7:0]  recent_r  [KEY_SLOTS];
	logic [3:0]  kptr_r    [KEY_SETS];
	logic [3:0]  kptr_nxt  [KEY_SETS];
	logic [15:0] pulse_cnt_r;
	logic [15:0] pulse_cnt_nxt;
	logic        supply_on_r;
	logic        power_switch_out_n_r;
	logic        pme_r;
	logic        panel_prev_r;
	logic        susp_prev_r;

	// ===========================================================
	// AHB-Lite slave: writes zero wait, reads one wait state
	logic        wr_pend_r;
	logic        rd_wait_r;
	logic [7:0]  idx_r;
	logic [31:0] hrdata_r;
	logic [7:0]  rd_val;
	logic        bus_wr;
	logic        status_rd;
	logic [6:0]  key_dec;
	logic        accept;

	assign accept    = hsel & htrans[1] & hready;
	assign bus_wr    = wr_pend_r;
	assign status_rd = rd_wait_r & (idx_r == IDX_STATUS); // R12
	assign key_dec   = key_decode(key_index_r); // R9
	assign hreadyout = ~rd_wait_r;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_wait_r <= 1'b0;
			idx_r     <= 8'h00;
		end else begin
			wr_pend_r <= accept & hwrite;
			rd_wait_r <= accept & ~hwrite;
			if (accept)
				idx_r <= haddr[9:2];
		end
	end

	always_comb begin
		rd_val = 8'h00;
		unique case (idx_r)
			IDX_ACTIVATE:  rd_val = activate_r;
			IDX_IRQ_SEL:   rd_val = irq_sel_r;
			IDX_WAKE_CTRL: rd_val = wake_ctrl_r;
			IDX_KEY_INDEX: rd_val = key_index_r;
			IDX_KEY_DATA: begin
				rd_val = KEY_FILL;
				if (key_dec[6])
					rd_val = key_mem_r[key_dec[5:4]][key_dec[3:0]]; // R11
				else if (key_index_r >= KEY_RECENT &&
					key_index_r < KEY_RECENT + 8'(SLOTS))
					rd_val = recent_r[4'(key_index_r - KEY_RECENT)]; // R10
			end
			IDX_STATUS: begin
				rd_val = {2'b00, status_r}; // R12
				rd_val[ST_LOSS_OFF] = status_r[ST_LOSS_OFF] &
					loss_ctrl_r[LC_SUPPLY_ON_N_MODE]; // R14
			end
			IDX_LOSS_CTRL: rd_val = loss_ctrl_r;
			IDX_AUX_CTRL:  rd_val = aux_ctrl_r;
			default:       rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_r <= 32'h0000_0000;
		else if (rd_wait_r)
			hrdata_r <= {24'h00_0000, rd_val};
	end

	// ===========================================================
	// Port routing and event detection
	logic       kb_vld;
	logic [7:0] kb_byte;
	logic       ms_vld;
	logic [7:0] ms_byte;
	logic       armed;
	logic       kb_evt;
	logic       ms_evt;
	logic       seq_hit;
	logic       wake_fire;
	logic       loss_on;
	logic       pulse_end;

	always_comb begin
		kb_vld  = port_a_valid;
		kb_byte = port_a_data;
		ms_vld  = port_b_valid;
		ms_byte = port_b_data;
		if (wake_ctrl_r[WC_SWAP]) begin // R7
			kb_vld  = port_b_valid;
			kb_byte = port_b_data;
			ms_vld  = port_a_valid;
			ms_byte = port_a_data;
		end
	end

	// Hunting arms detection even while the unit is inactive
	assign armed = activate_r[0] | loss_ctrl_r[LC_HUNT]; // R1 R21

	// Key sequence trackers; a set whose first entry is zero is off
	always_comb begin
		seq_hit = 1'b0;
		for (int s = 0; s < KEY_SETS; s++) begin
			kptr_nxt[s] = kptr_r[s];
			if (kb_vld && key_mem_r[s][0] != KEY_END) begin
				if (kb_byte == key_mem_r[s][kptr_r[s]]) begin
					if (kptr_r[s] == SLOT_LAST ||
						key_mem_r[s][kptr_r[s] + 4'd1] == KEY_END) begin
						seq_hit     = 1'b1;
						kptr_nxt[s] = 4'd0;
					end else begin
						kptr_nxt[s] = kptr_r[s] + 4'd1;
					end
				end else begin
					kptr_nxt[s] = (kb_byte == key_mem_r[s][0]) ?
						4'd1 : 4'd0;
				end
			end
		end
	end

	assign kb_evt = armed & kb_vld &
		(wake_ctrl_r[WC_KB_ANY] | seq_hit); // R8

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int s = 0; s < KEY_SETS; s++)
				kptr_r[s] <= 4'd0;
			for (int j = 0; j < KEY_SLOTS; j++)
				recent_r[j] <= KEY_FILL;
		end else begin
			kptr_r <= kptr_nxt;
			if (kb_vld) begin // R10
				recent_r[0] <= kb_byte;
				for (int j = 1; j < KEY_SLOTS; j++)
					recent_r[j] <= recent_r[j - 1];
			end
		end
	end

	// Mouse packets: three bytes, first byte carries the sync bit
	awpc_ms_state_t ms_state_r;
	logic [1:0]     ms_btn_r;
	logic [1:0]     ms_prev_r;
	logic           ms_move_r;
	logic           ms_half_r;
	logic [1:0]     ms_press;
	logic           ms_done;
	logic           ms_moved;
	logic           ms_sel;

	assign ms_done  = ms_vld & (ms_state_r == MS_B2);
	assign ms_moved = ms_move_r | (ms_byte != 8'h00);
	assign ms_press = ms_btn_r & ~ms_prev_r;
	assign ms_sel   = wake_ctrl_r[WC_MS_RIGHT] ? ms_press[1] : ms_press[0];

	always_comb begin
		ms_evt = 1'b0;
		if (ms_done && armed) begin
			if (aux_ctrl_r[AX_MS_EXT]) // R6
				ms_evt = wake_ctrl_r[WC_MS_ANY] ?
					((|ms_btn_r) | ms_moved) : (|ms_press);
			else
				ms_evt = ms_sel &
					(wake_ctrl_r[WC_MS_ANY] | ms_half_r); // R6
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ms_state_r <= MS_B0;
			ms_btn_r   <= 2'b00;
			ms_prev_r  <= 2'b00;
			ms_move_r  <= 1'b0;
			ms_half_r  <= 1'b0;
		end else if (ms_vld) begin
			unique case (ms_state_r)
				MS_B0: if ((ms_byte & MS_SYNC) != 8'h00) begin
					ms_btn_r   <= ms_byte[1:0];
					ms_state_r <= MS_B1;
				end
				MS_B1: begin
					ms_move_r  <= (ms_byte != 8'h00);
					ms_state_r <= MS_B2;
				end
				MS_B2: begin
					ms_prev_r  <= ms_btn_r;
					ms_state_r <= MS_B0;
					if (ms_sel && armed)
						ms_half_r <= ~ms_half_r & ~ms_evt;
				end
				default: ms_state_r <= MS_B0;
			endcase
		end
	end

	// ===========================================================
	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			activate_r  <= RST_ACTIVATE;
			irq_sel_r   <= RST_IRQ_SEL;
			wake_ctrl_r <= RST_WAKE_CTRL;
			key_index_r <= RST_KEY_INDEX;
			aux_ctrl_r  <= RST_AUX_CTRL;
		end else if (bus_wr) begin
			unique case (idx_r)
				IDX_ACTIVATE:  activate_r  <= hwdata[7:0] & MSK_ACTIVATE;
				IDX_IRQ_SEL:   irq_sel_r   <= hwdata[7:0] & MSK_IRQ_SEL;
				IDX_WAKE_CTRL: wake_ctrl_r <= hwdata[7:0] & MSK_WAKE_CTRL;
				IDX_KEY_INDEX: key_index_r <= hwdata[7:0];
				IDX_AUX_CTRL:  aux_ctrl_r  <= hwdata[7:0] & MSK_AUX_CTRL;
				default: ;
			endcase
		end
	end

	// Reset by hresetn like the other registers; no separate standby-domain reset
	always_ff @(posedge hclk or negedge hresetn) begin // R23
		if (!hresetn) begin
			for (int s = 0; s < KEY_SETS; s++)
				for (int j = 0; j < KEY_SLOTS; j++)
					key_mem_r[s][j] <= KEY_FILL; // R11
		end else if (bus_wr && idx_r == IDX_KEY_DATA && key_dec[6]) begin
			key_mem_r[key_dec[5:4]][key_dec[3:0]] <= hwdata[7:0]; // R9
		end
	end

	// Software setting the hunt bit wins over the hardware clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			loss_ctrl_r <= RST_LOSS_CTRL;
		else if (bus_wr && idx_r == IDX_LOSS_CTRL)
			loss_ctrl_r <= hwdata[7:0] & MSK_LOSS_CTRL;
		else if (kb_evt | ms_evt)
			loss_ctrl_r[LC_HUNT] <= 1'b0; // R21
	end

	// ===========================================================
	// Event status, set wins over the read clear
	assign loss_on = mains_return & decide_on(
		loss_ctrl_r[LC_POLICY_HI:LC_POLICY_LO], supply_on_r,
		aux_ctrl_r[AX_LAST_STATE]); // R19

	always_comb begin
		status_set              = 6'h00;
		status_set[ST_STANDBY]  = standby_return; // R13
		status_set[ST_LOSS_OFF] = mains_return & ~loss_on; // R14
		status_set[ST_THERMAL]  = thermal_event; // R15
		status_set[ST_PANEL]    = panel_prev_r & ~panel_switch_in; // R16
		status_set[ST_MOUSE]    = ms_evt; // R17
		status_set[ST_KEY]      = kb_evt; // R17
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			status_r <= RST_STATUS[5:0];
		else
			status_r <= (status_r & ~(status_rd ? MSK_STATUS[5:0] :
				6'h00)) | status_set; // R12
	end

	// ===========================================================
	// Power switch pulse and supply control
	assign wake_fire = (kb_evt & wake_ctrl_r[WC_KB_EN]) | // R4
		(ms_evt & wake_ctrl_r[WC_MS_EN]) | // R5
		(loss_on & ~loss_ctrl_r[LC_SUPPLY_ON_N_MODE]);
	assign pulse_end = (pulse_cnt_r == 16'd1);

	always_comb begin
		pulse_cnt_nxt = pulse_cnt_r;
		if (pulse_cnt_r != 16'd0)
			pulse_cnt_nxt = pulse_cnt_r - 16'd1;
		else if (wake_fire)
			pulse_cnt_nxt = PULSE_LEN; // R22
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_cnt_r  <= 16'd0;
			power_switch_out_n_r      <= 1'b1;
			panel_prev_r <= 1'b1;
			susp_prev_r  <= 1'b1;
			pme_r        <= 1'b1;
		end else begin
			pulse_cnt_r  <= pulse_cnt_nxt;
			power_switch_out_n_r      <= (pulse_cnt_nxt == 16'd0) &
				(wake_ctrl_r[WC_PANEL_BLOCK] | panel_switch_in); // R3
			panel_prev_r <= panel_switch_in;
			susp_prev_r  <= suspend_state_n;
			pme_r        <= ~(activate_r[0] & (|status_r));
		end
	end

	// Supply drops when the chipset enters suspend
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			supply_on_r <= 1'b0;
		else if (!loss_ctrl_r[LC_SUPPLY_ON_N_MODE] && pulse_end)
			supply_on_r <= 1'b1; // R18
		else if (loss_ctrl_r[LC_SUPPLY_ON_N_MODE] && suspend_state_n &&
			(loss_on || !susp_prev_r))
			supply_on_r <= 1'b1; // R18
		else if (susp_prev_r && !suspend_state_n)
			supply_on_r <= 1'b0;
	end

	assign power_switch_out_n = power_switch_out_n_r;
	assign supply_on_n        = ~supply_on_r;
	assign power_event_n      = pme_r;
	assign irq_line_select    = irq_sel_r[3:0]; // R2

	// ===========================================================
	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_pulse_start;
		pulse_cnt_r == 16'd0 ##1 pulse_cnt_r == PULSE_LEN;
	endsequence

	sequence s_pulse_low2;
		!power_switch_out_n [*2];
	endsequence

	a_pulse_low_out: assert property ( // R22
		s_pulse_start |-> s_pulse_low2 or pulse_cnt_r == 16'd1)
		else $error("power switch output not low during pulse");
	a_kb_wake_gate: assert property ( // R4
		kb_evt && !wake_ctrl_r[WC_KB_EN] && !ms_evt && !loss_on
		&& pulse_cnt_r == 16'd0 |=> pulse_cnt_r == 16'd0)
		else $error("keyboard wake pulsed while disabled");
	a_ms_wake_gate: assert property ( // R5
		ms_evt && wake_ctrl_r[WC_MS_EN] && pulse_cnt_r == 16'd0
		|=> pulse_cnt_r == PULSE_LEN ##1 !power_switch_out_n)
		else $error("mouse wake did not start pulse");
	a_status_rd_clr: assert property ( // R12
		status_rd && status_set == 6'h00 |=> status_r == 6'h00)
		else $error("status not cleared by read");
	a_panel_blocked: assert property ( // R3
		wake_ctrl_r[WC_PANEL_BLOCK] && pulse_cnt_r == 16'd0 &&
		!wake_fire |=> power_switch_out_n)
		else $error("blocked panel switch reached output");
	a_hunt_self_clr: assert property ( // R21
		(kb_evt || ms_evt) && !(bus_wr && idx_r == IDX_LOSS_CTRL)
		|=> !loss_ctrl_r[LC_HUNT] && (status_r[ST_KEY] ||
		status_r[ST_MOUSE]))
		else $error("hunt bit not cleared on wake capture");
	a_thermal_flag: assert property ( // R15
		thermal_event |=> status_r[ST_THERMAL])
		else $error("thermal event not latched");
	a_loss_bit_mask: assert property ( // R14
		rd_wait_r && idx_r == IDX_STATUS && !loss_ctrl_r[LC_SUPPLY_ON_N_MODE]
		|=> !hrdata[ST_LOSS_OFF])
		else $error("loss bit visible while control clear");
	a_supply_after: assert property ( // R18
		pulse_end && !loss_ctrl_r[LC_SUPPLY_ON_N_MODE] |=> !supply_on_n)
		else $error("supply not on after switch pulse");

endmodule : awpc_wake_power

`default_nettype wire

/* test/awpc_far_model.sv */
// Far-side model: keyboard and mouse ports, panel switch, suspend line
`timescale 1ns/100ps
`default_nettype none
module awpc_far_model (
	input  wire logic       hclk,
	output logic            port_a_valid,
	output logic [7:0]      port_a_data,
	output logic            port_b_valid,
	output logic [7:0]      port_b_data,
	output logic            panel_switch_in,
	output logic            suspend_state_n
);
	// ==========================================================
	// Idle levels; the switch has a pull-up, so released is high
	initial begin
		port_a_valid    = 1'h0;
		port_a_data     = 8'h00;
		port_b_valid    = 1'h0;
		port_b_data     = 8'h00;
		panel_switch_in = 1'h1;
		suspend_state_n = 1'h1;
	end

	// ==========================================================
	// Byte sender; stale data is inverted so no old value lingers
	task automatic send(input logic chan, input logic [7:0] b);
		@(posedge hclk);
		port_a_valid <= ~chan;
		port_b_valid <= chan;
		if (chan)
			port_b_data <= b;
		else
			port_a_data <= b;
		@(posedge hclk);
		port_a_valid <= 1'h0;
		port_b_valid <= 1'h0;
		if (chan)
			port_b_data <= ~b;
		else
			port_a_data <= ~b;
		// Real devices are slow; leave a gap between bytes
		repeat (3) @(posedge hclk);
	endtask : send

	task automatic packet(input logic [7:0] b0, b1, b2);
		send(1'h1, b0);
		send(1'h1, b1);
		send(1'h1, b2);
	endtask : packet

	task automatic press(input int n);
		@(posedge hclk);
		panel_switch_in <= 1'h0;
		repeat (n) @(posedge hclk);
		panel_switch_in <= 1'h1;
	endtask : press

	task automatic susp(input logic v);
		@(posedge hclk);
		suspend_state_n <= v;
	endtask : susp
endmodule : awpc_far_model
`default_nettype wire

/* test/awpc_wake_power_tb.sv */
// Self-checking bench for the wake and power-loss control unit
`timescale 1ns/100ps
`default_nettype none
module awpc_wake_power_tb
	import awpc_pkg::*;
;
	localparam int PC = 4;
	localparam logic [7:0] RI [13] = '{8'h30, 8'h70, 8'h70, 8'he0, 8'he1,
		8'he2, 8'he1, 8'he2, 8'he4, 8'he6, 8'h31, 8'he3, 8'he3};
	localparam logic [7:0] RW [13] = '{8'hff, 8'hff, 8'h05, 8'hff, 8'h4e,
		8'h5a, 8'h4f, 8'h33, 8'h60, 8'hff, 8'hff, 8'hff, 8'h00};
	localparam logic [7:0] RE [13] = '{8'h01, 8'h0f, 8'h05, 8'hf7, 8'h4e,
		8'h5a, 8'h4f, 8'hff, 8'h60, 8'h90, 8'h00, 8'h08, 8'h00};
	localparam logic [7:0] SI [8] = '{8'h30, 8'h70, 8'he0, 8'he1, 8'he2,
		8'he3, 8'he4, 8'he6};
	localparam logic [7:0] SE [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'hff,
		8'h08, 8'h00, 8'h10};

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        thermal_event, standby_return, mains_return;
	logic        power_switch_out_n, supply_on_n, power_event_n;
	logic [3:0]  irq_line_select;
	logic        port_a_valid, port_b_valid, panel_switch_in;
	logic        suspend_state_n;
	logic [7:0]  port_a_data, port_b_data;
	int          error_cnt, samples_checked, cyc, n;

	awpc_wake_power #(.SLOTS(15), .PULSE_CYCLES(PC)) i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .port_a_valid(port_a_valid),
		.port_a_data(port_a_data), .port_b_valid(port_b_valid),
		.port_b_data(port_b_data), .panel_switch_in(panel_switch_in),
		.suspend_state_n(suspend_state_n), .thermal_event(thermal_event),
		.standby_return(standby_return), .mains_return(mains_return),
		.power_switch_out_n(power_switch_out_n), .supply_on_n(supply_on_n),
		.power_event_n(power_event_n), .irq_line_select(irq_line_select));

	awpc_far_model u_far (
		.hclk(hclk), .port_a_valid(port_a_valid),
		.port_a_data(port_a_data), .port_b_valid(port_b_valid),
		.port_b_data(port_b_data), .panel_switch_in(panel_switch_in),
		.suspend_state_n(suspend_state_n));

	always #2 hclk = ~hclk;

	// ==========================================================
	// Helpers
	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// Hang guard, well above the roughly one thousand cycles the run needs
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {22'h0, i, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'h1, i, {24'h0, d});
	endtask : wr

	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		bus(1'h0, i, 32'h0);
		chk(rd, {24'h0, e});
		chk({31'h0, hresp}, 32'h0);
	endtask : rdc

	task automatic strobe(input int k);
		@(posedge hclk);
		thermal_event  <= (k == 0);
		standby_return <= (k == 1);
		mains_return   <= (k == 2);
		@(posedge hclk);
		thermal_event  <= 1'h0;
		standby_return <= 1'h0;
		mains_return   <= 1'h0;
		repeat (3) @(posedge hclk);
	endtask : strobe

	// Counts low cycles of the power switch output over a window
	task automatic pl(output int c);
		c = 0;
		repeat (30) begin
			@(posedge hclk);
			if (power_switch_out_n !== 1'h1)
				c++;
		end
	endtask : pl

	task automatic kb(input logic ch, input logic [7:0] b, input int e);
		fork
			u_far.send(ch, b);
			pl(n);
		join
		chk(n, e);
	endtask : kb

	task automatic ms(input logic [7:0] b0, b1, input int e);
		fork
			u_far.packet(b0, b1, 8'h00);
			pl(n);
		join
		chk(n, e);
	endtask : ms

	// ==========================================================
	// Sequence
	initial begin
		hclk = 1'h0;
		hresetn = 1'h0;
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		thermal_event = 1'h0;
		standby_return = 1'h0;
		mains_return = 1'h0;
		error_cnt = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		for (int k = 0; k < 13; k++) begin
			wr(RI[k], RW[k]);
			rdc(RI[k], RE[k]);
			if (RI[k] == IDX_IRQ_SEL)
				chk({28'h0, irq_line_select}, {28'h0, RE[k][3:0]});
		end
		$display("register table done");
		@(posedge hclk);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		chk({31'h0, supply_on_n}, 32'h1);
		chk({28'h0, irq_line_select}, 32'h0);
		hresetn <= 1'h1;
		for (int k = 0; k < 8; k++)
			rdc(SI[k], SE[k]);
		$display("reset values done");
		strobe(0);
		rdc(IDX_STATUS, 8'h08);
		strobe(1);
		rdc(IDX_STATUS, 8'h20);
		rdc(IDX_STATUS, 8'h00);
		wr(IDX_ACTIVATE, 8'h01);
		strobe(0);
		chk({31'h0, power_event_n}, 32'h0);
		rdc(IDX_STATUS, 8'h08);
		repeat (2) @(posedge hclk);
		chk({31'h0, power_event_n}, 32'h1);
		$display("status events done");
		fork
			u_far.press(6);
			pl(n);
		join
		chk(n, 6);
		rdc(IDX_STATUS, 8'h04);
		wr(IDX_WAKE_CTRL, 8'h81);
		fork
			u_far.press(6);
			pl(n);
		join
		chk(n, 0);
		bus(1'h0, IDX_STATUS, 32'h0);
		$display("panel switch done");
		wr(IDX_WAKE_CTRL, 8'h41);
		kb(1'h0, 8'h1c, PC);
		rdc(IDX_STATUS, 8'h01);
		wr(IDX_WAKE_CTRL, 8'h01);
		kb(1'h0, 8'h1c, 0);
		wr(IDX_KEY_INDEX, 8'h00);
		wr(IDX_KEY_DATA, 8'h1c);
		wr(IDX_KEY_INDEX, 8'h01);
		wr(IDX_KEY_DATA, 8'h32);
		wr(IDX_KEY_INDEX, 8'h02);
		wr(IDX_KEY_DATA, 8'h00);
		wr(IDX_WAKE_CTRL, 8'h40);
		bus(1'h0, IDX_STATUS, 32'h0);
		kb(1'h0, 8'h32, 0);
		u_far.send(1'h0, 8'h1c);
		kb(1'h0, 8'h32, PC);
		rdc(IDX_STATUS, 8'h01);
		wr(IDX_KEY_INDEX, 8'h10);
		rdc(IDX_KEY_DATA, 8'h32);
		wr(IDX_KEY_INDEX, 8'h01);
		rdc(IDX_KEY_DATA, 8'h32);
		wr(IDX_WAKE_CTRL, 8'h45);
		kb(1'h1, 8'h1c, PC);
		rdc(IDX_STATUS, 8'h01);
		$display("keyboard wake done");
		wr(IDX_AUX_CTRL, 8'h80);
		wr(IDX_WAKE_CTRL, 8'h02);
		ms(8'h08, 8'h05, 0);
		wr(IDX_WAKE_CTRL, 8'h22);
		bus(1'h0, IDX_STATUS, 32'h0);
		ms(8'h08, 8'h05, PC);
		rdc(IDX_STATUS, 8'h02);
		wr(IDX_AUX_CTRL, 8'h00);
		wr(IDX_WAKE_CTRL, 8'h30);
		ms(8'h0a, 8'h00, 0);
		u_far.packet(8'h08, 8'h00, 8'h00);
		ms(8'h0a, 8'h00, PC);
		wr(IDX_AUX_CTRL, 8'h80);
		wr(IDX_WAKE_CTRL, 8'h20);
		ms(8'h09, 8'h00, PC);
		$display("mouse wake done");
		wr(IDX_ACTIVATE, 8'h00);
		wr(IDX_WAKE_CTRL, 8'h41);
		kb(1'h0, 8'h1c, 0);
		wr(IDX_LOSS_CTRL, 8'h04);
		kb(1'h0, 8'h1c, PC);
		rdc(IDX_LOSS_CTRL, 8'h00);
		$display("hunting mode done");
		wr(IDX_ACTIVATE, 8'h01);
		u_far.susp(1'h0);
		wr(IDX_LOSS_CTRL, 8'h80);
		bus(1'h0, IDX_STATUS, 32'h0);
		strobe(2);
		chk({31'h0, supply_on_n}, 32'h1);
		rdc(IDX_STATUS, 8'h10);
		wr(IDX_LOSS_CTRL, 8'he0);
		wr(IDX_AUX_CTRL, 8'h10);
		strobe(2);
		chk({31'h0, supply_on_n}, 32'h1);
		rdc(IDX_STATUS, 8'h10);
		wr(IDX_LOSS_CTRL, 8'h60);
		strobe(2);
		rdc(IDX_STATUS, 8'h00);
		u_far.susp(1'h1);
		wr(IDX_LOSS_CTRL, 8'ha0);
		strobe(2);
		chk({31'h0, supply_on_n}, 32'h0);
		u_far.susp(1'h0);
		repeat (3) @(posedge hclk);
		chk({31'h0, supply_on_n}, 32'h1);
		wr(IDX_LOSS_CTRL, 8'h20);
		fork
			strobe(2);
			pl(n);
		join
		chk(n, PC);
		chk({31'h0, supply_on_n}, 32'h0);
		wr(IDX_LOSS_CTRL, 8'h40);
		fork
			strobe(2);
			pl(n);
		join
		chk(n, PC);
		u_far.susp(1'h1);
		u_far.susp(1'h0);
		repeat (2) @(posedge hclk);
		fork
			strobe(2);
			pl(n);
		join
		chk(n, 0);
		chk({31'h0, supply_on_n}, 32'h1);
		wr(IDX_AUX_CTRL, 8'h00);
		wr(IDX_LOSS_CTRL, 8'h60);
		fork
			strobe(2);
			pl(n);
		join
		chk(n, PC);
		$display("power loss done");
		close_out();
	end
endmodule : awpc_wake_power_tb
`default_nettype wire
